// ===== rtl/aux2_irq_pkg.sv
// Purpose: Constants and carriers for the aux output / timing error slice
// Assumes: 8-bit registers, 5-bit register address on the serial port
// Notes:   Reserved addresses read zero
//
// How it works
// - Level word from 0x11 and 0x12 bits 1:0
// - Bit 9 MSB, current rises with value
// - Bit 7 pin select, bit 6 direction
// - Bit 5 powers down; fields reset zero
// - Data timing violation latches bit 7
// - Sync timing violation latches bit 6
// - Reading interrupt register clears both flags
// - Bit 4 reports hold or setup kind
// - Bit 3 enables data error interrupt
// - Bit 2 enables sync error interrupt
// - Bit 0 loops sync output to input
// - Read-only revision byte at 0x1F
package aux2_irq_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] ADDR_AUX2_LOW  = 5'h11;
  localparam logic [4:0] ADDR_AUX2_HIGH = 5'h12;
  localparam logic [4:0] ADDR_IRQ       = 5'h19;
  localparam logic [4:0] ADDR_REV       = 5'h1F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_AUX2_NEG    = 7;
  localparam int BIT_AUX2_SINK   = 6;
  localparam int BIT_AUX2_PDOWN  = 5;
  localparam int BIT_DATA_FLAG   = 7;
  localparam int BIT_SYNC_FLAG   = 6;
  localparam int BIT_ERR_KIND    = 4;
  localparam int BIT_DATA_EN     = 3;
  localparam int BIT_SYNC_EN     = 2;
  localparam int BIT_LOOPBACK    = 0;
  localparam int BIT_INSTR_READ  = 7;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int         LEVEL_W    = 10;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic               neg_sel;
    logic               sink;
    logic               pdown;
  } aux2_ctrl_s;

  typedef enum logic [4:0] {
    SP_IDLE  = 5'h01,
    SP_INSTR = 5'h02,
    SP_WRITE = 5'h04,
    SP_READ  = 5'h08,
    SP_DONE  = 5'h10
  } spi_state_e;

endpackage : aux2_irq_pkg

// ===== rtl/pin_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to core_clk_in
// Notes:   Stage one feeds only stage two
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // Change counts once stages two and three agree
      always_comb
      begin
        nxt_level[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : level_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      level_ff <= '0;
    end
    else
    begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule : pin_sync3

// ===== rtl/sticky_flag.sv
// Purpose: Latched event flag, cleared by a strobe
// Assumes: Set and clear on core_clk_in
// Notes:   Set wins over clear so no event is lost
`timescale 1ns/100ps
module sticky_flag (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  // Event and clear
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_ff;
  logic nxt_flag;

  always_comb
  begin
    nxt_flag = set_in | (flag_ff & ~clr_in);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_out = flag_ff;

endmodule : sticky_flag

// ===== rtl/aux2_irq_regs.sv
// Purpose: Aux output two controls, timing error interrupt, revision
// Assumes: Serial port pins asynchronous; error strobes on core clock
// Notes:   Instruction byte then one data byte, MSB first
`timescale 1ns/100ps
module aux2_irq_regs #(
  // Arbitrary value, not a real part revision
  parameter logic [7:0] HW_REV = 8'h3C
) (
  // Clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     nrst_in,
  // Serial control port
  input  wire logic                     spi_cs_n_in,
  input  wire logic                     spi_sclk_in,
  input  wire logic                     sdio_in,
  output logic                          sdio_out,
  output logic                          sdio_oe_out,
  // Timing violation detectors
  input  wire logic                     data_hold_err_in,
  input  wire logic                     data_setup_err_in,
  input  wire logic                     sync_err_in,
  // Sync paths
  input  wire logic                     sync_pin_in,
  input  wire logic                     sync_out_rx_in,
  output logic                          sync_path_out,
  // Aux output two and interrupt
  output aux2_irq_pkg::aux2_ctrl_s      aux2_ctrl_out,
  output logic                          irq_out
);
  import aux2_irq_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pins_lvl;
  logic       cs_n;
  logic       sclk;
  logic       sdi;

  pin_sync3 #(.WIDTH(3)) u_pins (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .pin_in      ({~spi_cs_n_in, spi_sclk_in, sdio_in}),
    .level_out   (pins_lvl)
  );

  // Select carried inverted so reset zero reads idle, no false frame
  assign cs_n = ~pins_lvl[2];
  assign sclk = pins_lvl[1];
  assign sdi  = pins_lvl[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  spi_state_e state_ff,   nxt_state;
  logic       sclk_d_ff,  nxt_sclk_d;
  logic [2:0] cnt_ff,     nxt_cnt;
  logic [7:0] shin_ff,    nxt_shin;
  logic [7:0] shout_ff,   nxt_shout;
  logic [4:0] addr_ff,    nxt_addr;
  logic       sdo_ff,     nxt_sdo;
  logic       oe_ff,      nxt_oe;
  logic [7:0] low_ff,     nxt_low;
  logic [7:0] high_ff,    nxt_high;
  logic       den_ff,     nxt_den;
  logic       sen_ff,     nxt_sen;
  logic       loop_ff,    nxt_loop;
  logic       kind_ff,    nxt_kind;
  logic       sync_ff,    nxt_sync;
  logic       irq_ff,     nxt_irq;
  logic       irq_rd_clr;
  logic       data_flag;
  logic       sync_flag;
  logic       data_evt;
  logic       rise;
  logic       fall;
  logic [7:0] in_byte;

  // Read mux used by the read path
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    logic [7:0] r;
    r = RST_BYTE;
    unique case (a)
      ADDR_AUX2_LOW:  r = low_ff;
      ADDR_AUX2_HIGH: r = high_ff;
      ADDR_IRQ:
      begin
        r[BIT_DATA_FLAG] = data_flag;
        r[BIT_SYNC_FLAG] = sync_flag;
        r[BIT_ERR_KIND]  = kind_ff;
        r[BIT_DATA_EN]   = den_ff;
        r[BIT_SYNC_EN]   = sen_ff;
        r[BIT_LOOPBACK]  = loop_ff;
      end
      ADDR_REV:       r = HW_REV;
      default:        r = RST_BYTE;
    endcase
    return r;
  endfunction : reg_read

  assign rise     = sclk & ~sclk_d_ff;
  assign fall     = ~sclk & sclk_d_ff;
  assign in_byte  = {shin_ff[6:0], sdi};
  assign data_evt = data_hold_err_in | data_setup_err_in;

  // ----------------------------------------
  // Serial port and register writes
  // ----------------------------------------
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_sclk_d = sclk;
    nxt_cnt    = cnt_ff;
    nxt_shin   = shin_ff;
    nxt_shout  = shout_ff;
    nxt_addr   = addr_ff;
    nxt_sdo    = sdo_ff;
    nxt_oe     = oe_ff;
    nxt_low    = low_ff;
    nxt_high   = high_ff;
    nxt_den    = den_ff;
    nxt_sen    = sen_ff;
    nxt_loop   = loop_ff;
    irq_rd_clr = 1'b0;
    if (cs_n)
    begin
      // Frame end aborts any partial byte
      nxt_state = SP_IDLE;
      nxt_oe    = 1'b0;
      nxt_cnt   = 3'h0;
    end
    else
    begin
      unique case (state_ff)
        SP_IDLE:
        begin
          nxt_state = SP_INSTR;
          nxt_cnt   = 3'h0;
        end
        SP_INSTR:
        begin
          if (rise)
          begin
            nxt_shin = in_byte;
            nxt_cnt  = cnt_ff + 3'h1;
            if (cnt_ff == BIT_CNT_LAST)
            begin
              nxt_addr = in_byte[4:0];
              if (in_byte[BIT_INSTR_READ])
              begin
                nxt_state = SP_READ;
                nxt_shout = reg_read(in_byte[4:0]);
                irq_rd_clr = (in_byte[4:0] == ADDR_IRQ);
              end
              else
                nxt_state = SP_WRITE;
            end
          end
        end
        SP_WRITE:
        begin
          if (rise)
          begin
            nxt_shin = in_byte;
            nxt_cnt  = cnt_ff + 3'h1;
            if (cnt_ff == BIT_CNT_LAST)
            begin
              nxt_state = SP_DONE;
              unique case (addr_ff)
                ADDR_AUX2_LOW:  nxt_low = in_byte;
                ADDR_AUX2_HIGH: nxt_high = in_byte & 8'hE3;
                ADDR_IRQ:
                begin
                  nxt_den  = in_byte[BIT_DATA_EN];
                  nxt_sen  = in_byte[BIT_SYNC_EN];
                  nxt_loop = in_byte[BIT_LOOPBACK];
                end
                default: nxt_low = low_ff;
              endcase
            end
          end
        end
        SP_READ:
        begin
          // Drive on falling edge, host samples on rising
          if (fall)
          begin
            nxt_oe    = 1'b1;
            nxt_sdo   = shout_ff[7];
            nxt_shout = {shout_ff[6:0], 1'b0};
          end
        end
        SP_DONE: nxt_state = SP_DONE;
      endcase
    end
  end

  // ----------------------------------------
  // Timing error flags
  // ----------------------------------------
  // data flag latch
  sticky_flag u_data_flag (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .set_in      (data_evt),
    .clr_in      (irq_rd_clr),
    .flag_out    (data_flag)
  );

  sticky_flag u_sync_flag (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .set_in      (sync_err_in),
    .clr_in      (irq_rd_clr),
    .flag_out    (sync_flag)
  );

  always_comb
  begin
    nxt_kind = data_evt ? data_setup_err_in : kind_ff;
    nxt_sync = loop_ff ? sync_out_rx_in : sync_pin_in;
    nxt_irq  = (data_flag & den_ff) | (sync_flag & sen_ff);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      state_ff  <= SP_IDLE;
      sclk_d_ff <= 1'b0;
      cnt_ff    <= 3'h0;
      shin_ff   <= RST_BYTE;
      shout_ff  <= RST_BYTE;
      addr_ff   <= 5'h00;
      sdo_ff    <= 1'b0;
      oe_ff     <= 1'b0;
      low_ff    <= RST_BYTE;
      high_ff   <= RST_BYTE;
      den_ff    <= 1'b0;
      sen_ff    <= 1'b0;
      loop_ff   <= 1'b0;
      kind_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      sclk_d_ff <= nxt_sclk_d;
      cnt_ff    <= nxt_cnt;
      shin_ff   <= nxt_shin;
      shout_ff  <= nxt_shout;
      addr_ff   <= nxt_addr;
      sdo_ff    <= nxt_sdo;
      oe_ff     <= nxt_oe;
      low_ff    <= nxt_low;
      high_ff   <= nxt_high;
      den_ff    <= nxt_den;
      sen_ff    <= nxt_sen;
      loop_ff   <= nxt_loop;
      kind_ff   <= nxt_kind;
      sync_ff   <= nxt_sync;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // level assembly, bit 9 MSB
  assign aux2_ctrl_out.level   = {high_ff[1:0], low_ff};
  assign aux2_ctrl_out.neg_sel = high_ff[BIT_AUX2_NEG];
  assign aux2_ctrl_out.sink    = high_ff[BIT_AUX2_SINK];
  assign aux2_ctrl_out.pdown   = high_ff[BIT_AUX2_PDOWN];
  assign sdio_out              = sdo_ff;
  assign sdio_oe_out           = oe_ff;
  assign sync_path_out         = sync_ff;
  assign irq_out               = irq_ff;

endmodule : aux2_irq_regs

// ===== tb/aux2_irq_regs_assertions.sv
// Purpose: Port checks for the aux output / timing error slice
// Assumes: One clock, synchronous active-low reset
// Notes:   Quiet means cs high for 8 clocks, so no frame effect is pending
`timescale 1ns/100ps
module aux2_irq_regs_assertions
  import aux2_irq_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       spi_cs_n_in,
  input wire logic       data_hold_err_in,
  input wire logic       data_setup_err_in,
  input wire logic       sync_err_in,
  input wire logic       sync_pin_in,
  input wire logic       sync_out_rx_in,
  input wire logic       sync_path_out,
  input wire logic       sdio_oe_out,
  input wire aux2_ctrl_s aux2_ctrl_out,
  input wire logic       irq_out
);
  logic [3:0] idle_ff;
  logic [3:0] nxt_idle;

  // Saturating so a long idle never wraps back to zero
  always_comb
  begin
    nxt_idle = spi_cs_n_in ? idle_ff + 4'h1 : 4'h0;
    if (spi_cs_n_in && idle_ff == 4'hF)
      nxt_idle = idle_ff;
  end

  always_ff @(posedge core_clk_in)
  begin
    idle_ff <= nrst_in ? nxt_idle : 4'h0;
  end

  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence quiet_s;
    idle_ff >= 4'h8;
  endsequence

  sequence settled_s;
    $past(nrst_in) && $past(nrst_in, 2);
  endsequence

  rst_out_a:
    assert property (disable iff (1'h0) !nrst_in |=> aux2_ctrl_out == '0 && !irq_out)
    else $error("outputs not cleared during reset");
  rst_rel_a:
    assert property ($rose(nrst_in) |-> aux2_ctrl_out == '0 && !sdio_oe_out)
    else $error("outputs not zero at reset release");
  aux_hold_a:
    assert property (quiet_s |=> $stable(aux2_ctrl_out))
    else $error("aux controls moved without a frame");
  irq_hold_a:
    assert property (quiet_s ##0 irq_out |=> irq_out)
    else $error("interrupt dropped without a read");
  irq_rise_a:
    assert property ($rose(irq_out) |->
      $past(data_hold_err_in || data_setup_err_in || sync_err_in, 2) || idle_ff < 4'h8)
    else $error("interrupt rose without a cause");
  oe_idle_a:
    assert property (quiet_s |-> !sdio_oe_out)
    else $error("data pin driven outside a frame");
  oe_rise_a:
    assert property ($rose(sdio_oe_out) |-> !spi_cs_n_in)
    else $error("data pin drive began with cs high");
  loop_sel_a:
    assert property (settled_s |->
      sync_path_out == $past(sync_pin_in) || sync_path_out == $past(sync_out_rx_in))
    else $error("sync path not one cycle behind a source");
endmodule : aux2_irq_regs_assertions

bind aux2_irq_regs aux2_irq_regs_assertions u_aux2_irq_regs_assertions (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .spi_cs_n_in(spi_cs_n_in),
  .data_hold_err_in(data_hold_err_in), .data_setup_err_in(data_setup_err_in),
  .sync_err_in(sync_err_in), .sync_pin_in(sync_pin_in), .sync_out_rx_in(sync_out_rx_in),
  .sync_path_out(sync_path_out), .sdio_oe_out(sdio_oe_out),
  .aux2_ctrl_out(aux2_ctrl_out), .irq_out(irq_out));

// ===== tb/spi_host_model.sv
// Purpose: Host model for the serial control port
// Assumes: Half period of HALF core clocks, well above the pin filter delay
// Notes:   Data released in the read phase; the bench resolves the wire
`timescale 1ns/100ps
module spi_host_model #(
  parameter int HALF = 8
) (
  // Clock and wire level
  input  wire logic  core_clk_in,
  input  wire logic  sdio_in,
  // Port pins
  output logic       cs_n_out,
  output logic       sclk_out,
  output logic       sdio_out,
  output logic       sdio_oe_out,
  // Read result
  output logic       rd_done_out,
  output logic [7:0] rd_data_out
);
  initial
  begin
    cs_n_out = 1'h1;
    sclk_out = 1'h0;
    sdio_out = 1'h0;
    sdio_oe_out = 1'h0;
    rd_done_out = 1'h0;
    rd_data_out = 8'h00;
  end

  // Clock stands low between frames
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wdat);
    logic [15:0] sh;
    sh = {rd, 2'h0, addr, wdat};
    @(negedge core_clk_in);
    cs_n_out = 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_out = 1'h0;
      sdio_out = sh[i];
      sdio_oe_out = !(rd && i < 8);
      repeat (HALF) @(negedge core_clk_in);
      if (rd && i < 8)
        rd_data_out[i] = sdio_in;
      sclk_out = 1'h1;
      repeat (HALF) @(negedge core_clk_in);
    end
    cs_n_out = 1'h1;
    sdio_oe_out = 1'h0;
    repeat (2) @(negedge core_clk_in);
    sclk_out = 1'h0;
    repeat (HALF) @(negedge core_clk_in);
    rd_done_out = rd;
    @(negedge core_clk_in);
    rd_done_out = 1'h0;
  endtask : xfer
endmodule : spi_host_model

// ===== tb/aux2_irq_regs_test.sv
// Purpose: Self-checking bench for the aux output / timing error slice
// Assumes: Host model frames; strobes driven on falling edges
// Notes:   Read results compared in order from a queue
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module aux2_irq_regs_test;
  import aux2_irq_pkg::*;
  // Arbitrary value, not a real part revision
  localparam logic [7:0] REV_VAL = 8'hA5;
  logic       core_clk_in = 1'h0;
  logic       nrst_in = 1'h0;
  logic       cs_n, sclk, host_d, host_oe, sdio_o, sdio_oe, spath, irq, rd_done;
  logic       hold = 1'h0, setup = 1'h0, serr = 1'h0, spin = 1'h0, srx = 1'h0, flip = 1'h0;
  logic [7:0] rd_data, lo, hi, e;
  logic [7:0] exp_q[$];
  aux2_ctrl_s ctrl, exp_ctrl;
  int         n_errors = 0, checked = 0;
  integer     seed = 27633;
  // Released wire toggles so a stale level cannot pass
  wire        sdio_wire = sdio_oe ? sdio_o : (host_oe ? host_d : flip);

  aux2_irq_regs #(.HW_REV(REV_VAL)) u_aux2_irq_regs (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
    .sdio_in(sdio_wire), .sdio_out(sdio_o), .sdio_oe_out(sdio_oe), .data_hold_err_in(hold),
    .data_setup_err_in(setup), .sync_err_in(serr), .sync_pin_in(spin),
    .sync_out_rx_in(srx), .sync_path_out(spath), .aux2_ctrl_out(ctrl), .irq_out(irq));
  spi_host_model u_spi_host_model (
    .core_clk_in(core_clk_in), .sdio_in(sdio_wire), .cs_n_out(cs_n), .sclk_out(sclk),
    .sdio_out(host_d), .sdio_oe_out(host_oe), .rd_done_out(rd_done), .rd_data_out(rd_data));

  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) flip <= ~flip;

  always @(posedge rd_done)
  begin
    e = exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data;
    `CHK(rd_data, e)
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_spi_host_model.xfer(1'h0, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    u_spi_host_model.xfer(1'h1, a, 8'h00);
  endtask : rd

  // k: 0 hold, 1 setup, 2 sync; x: expected interrupt
  task automatic pulse(input int k, input logic x);
    @(negedge core_clk_in);
    {serr, setup, hold} = 3'(1 << k);
    @(negedge core_clk_in);
    {serr, setup, hold} = 3'h0;
    repeat (2) @(negedge core_clk_in);
    `CHK(irq, x)
  endtask : pulse

  task automatic final_report();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (30000) @(posedge core_clk_in);
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (12) @(negedge core_clk_in);
    nrst_in = 1'h1;
    repeat (6) @(negedge core_clk_in);
    `CHK(ctrl, 13'h0000)
    rd(ADDR_AUX2_HIGH, 8'h00);
    rd(ADDR_IRQ, 8'h00);
    wr(ADDR_REV, ~REV_VAL);
    rd(ADDR_REV, REV_VAL);
    for (int n = 0; n < 4; n++)
    begin
      lo = n[0] ? 8'hFF : 8'($random(seed));
      hi = n[0] ? 8'hFF : 8'($random(seed));
      wr(ADDR_AUX2_LOW, lo);
      wr(ADDR_AUX2_HIGH, hi);
      exp_ctrl = {hi[1:0], lo, hi[7:5]};
      `CHK(ctrl, exp_ctrl)
      rd(ADDR_AUX2_LOW, lo);
      rd(ADDR_AUX2_HIGH, hi & 8'hE3);
    end
    for (int a = 8'h13; a < 8'h19; a++)
    begin
      wr(5'(a), 8'hFF);
      rd(5'(a), 8'h00);
    end
    rd(5'h00, 8'h00);
    `CHK(ctrl, exp_ctrl)
    wr(ADDR_IRQ, 8'hFC);
    rd(ADDR_IRQ, 8'h0C);
    pulse(1, 1'h1);
    pulse(2, 1'h1);
    rd(ADDR_IRQ, 8'hDC);
    rd(ADDR_IRQ, 8'h1C);
    `CHK(irq, 1'h0)
    wr(ADDR_IRQ, 8'h04);
    pulse(0, 1'h0);
    pulse(2, 1'h1);
    rd(ADDR_IRQ, 8'hC4);
    wr(ADDR_IRQ, 8'h08);
    pulse(2, 1'h0);
    rd(ADDR_IRQ, 8'h48);
    for (int n = 0; n < 12; n++)
    begin
      if (n == 6)
        wr(ADDR_IRQ, 8'h05);
      {spin, srx} = 2'($random(seed));
      @(negedge core_clk_in);
      `CHK(spath, n < 6 ? spin : srx)
    end
    pulse(2, 1'h1);
    nrst_in = 1'h0;
    repeat (3) @(negedge core_clk_in);
    nrst_in = 1'h1;
    repeat (2) @(negedge core_clk_in);
    `CHK(ctrl, 13'h0000)
    `CHK(irq, 1'h0)
    `CHK(spath, spin)
    repeat (4) @(negedge core_clk_in);
    rd(ADDR_IRQ, 8'h00);
    final_report();
  end
endmodule : aux2_irq_regs_test
